// ---- atw_defs.vh ----
`ifndef ATW_DEFS_VH
`define ATW_DEFS_VH
// Summary of operation
// - falling clock in sleep starts conversion
// - channel selects latched on start edge
// - code 00..11 routes inputs one to four
// - window edges drop one bit, halve time
// - data line low while converting, except while a reduction edge is acknowledged
// - after conversion, each falling edge shifts MSB-first
// - power-fail flag low while sense below reference
// - reset output low while supply sense low
// - reference output undriven during sleep
// - accepted reduction edge acknowledged high until release
// - completion drives data high, result held
// - at most six reductions, floor ten bits
// - seventeen falling edges per full cycle

// register byte offsets
`define ATW_ADDR_CTRL 8'h00
`define ATW_ADDR_STATUS 8'h04
`define ATW_ADDR_INT_STAT 8'h08
`define ATW_ADDR_INT_MASK 8'h0C
`define ATW_ADDR_RESULT 8'h10

// control fields
`define ATW_CTRL_ENABLE 0
`define ATW_CTRL_RESET 32'h0000_0001

// interrupt bits
`define ATW_INT_WIDTH 5
`define ATW_INT_START 0
`define ATW_INT_DONE 1
`define ATW_INT_READ 2
`define ATW_INT_PFAIL 3
`define ATW_INT_SUPPLY 4

// converter figures
`define ATW_RES_BITS 16
`define ATW_MAX_REDUCE 6
// internal oscillator 520 kHz against a 10 MHz system clock
`define ATW_OSC_KHZ 520
`define ATW_CLK_KHZ 10000
`define ATW_OSC_DIV (`ATW_CLK_KHZ / `ATW_OSC_KHZ)
// full-resolution conversion 125 ms, window is that over 85.7
`define ATW_CONV_US 125000
`define ATW_CONV_OSC ((`ATW_CONV_US * `ATW_OSC_KHZ) / 1000)
`define ATW_WINDOW_OSC ((`ATW_CONV_OSC * 10) / 857)
// reset held for twice the conversion time after recovery
`define ATW_HOLD_CYCLES ((2 * `ATW_CONV_US) * (`ATW_CLK_KHZ / 1000))
`endif

// ---- atw_sync.v ----
module atw_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire sys_rst,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_q;
  reg [WIDTH-1:0] stage2_q;

  // first stage feeds only the second
  always @(posedge clk) begin
    if (sys_rst) begin
      stage1_q <= {WIDTH{1'b0}};
      stage2_q <= {WIDTH{1'b0}};
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;
endmodule // atw_sync

// ---- atw_conv_ctrl.v ----
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`include "atw_defs.vh"

module atw_conv_ctrl #(
  parameter RES_BITS = `ATW_RES_BITS,
  parameter MAX_REDUCE = `ATW_MAX_REDUCE,
  parameter OSC_DIV = `ATW_OSC_DIV,
  parameter CONV_OSC_CYCLES = `ATW_CONV_OSC,
  parameter WINDOW_OSC_CYCLES = `ATW_WINDOW_OSC,
  parameter HOLD_CYCLES = `ATW_HOLD_CYCLES
) (
  input wire clk,
  input wire sys_rst,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  input wire serialClk,
  input wire channelSelectLow,
  input wire channelSelectHigh,
  output wire serialResultOut,
  input wire [RES_BITS-1:0] modulatorResult,
  output wire [3:0] muxInputSel,
  output wire referenceDriveEn,
  input wire powerFailSenseLow,
  input wire supplyMonitorSenseLow,
  input wire powerFailFlagNIn,
  output wire powerFailFlagNOut,
  output wire powerFailFlagNOeN,
  input wire resetNIn,
  output wire resetNOut,
  output wire resetNOeN,
  output wire irq
);
  localparam ST_SLEEP = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_READ = 3'b100;
  localparam integer CONV_I = CONV_OSC_CYCLES;
  localparam integer WIN_I = WINDOW_OSC_CYCLES;
  localparam integer DIV_I = OSC_DIV - 1;
  localparam integer REDUCE_I = MAX_REDUCE;
  localparam integer RES_I = RES_BITS;
  localparam integer HOLD_I = HOLD_CYCLES;
  localparam integer CTRL_I = `ATW_CTRL_RESET;
  // counters sized for the default figures; larger ones need wider regs
  localparam [19:0] CONV_LEN = CONV_I[19:0];
  localparam [19:0] WIN_LEN = WIN_I[19:0];
  localparam [7:0] DIV_LAST = DIV_I[7:0];
  localparam [2:0] REDUCE_MAX = REDUCE_I[2:0];
  localparam [4:0] RES_FULL = RES_I[4:0];
  localparam [31:0] HOLD_LEN = HOLD_I[31:0];
  localparam [31:0] CTRL_RESET = CTRL_I[31:0];

  wire [6:0] syncVec;
  wire sclkS;
  wire selHighS;
  wire selLowS;
  wire pfLowS;
  wire supLowS;
  wire pfPinS;
  wire rstPinS;

  atw_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .asyncIn({serialClk, channelSelectHigh, channelSelectLow,
      powerFailSenseLow, supplyMonitorSenseLow, powerFailFlagNIn,
      resetNIn}),
    .syncOut(syncVec)
  );

  assign {sclkS, selHighS, selLowS, pfLowS, supLowS, pfPinS, rstPinS} =
    syncVec;

  reg [2:0] state_q;
  reg sclkPrev_q;
  reg [1:0] channel_q;
  reg [2:0] reduce_q;
  reg winOpen_q;
  reg [7:0] divCnt_q;
  reg [19:0] oscCnt_q;
  reg serial_result_out_q;
  reg [RES_BITS-1:0] shift_q;
  reg [RES_BITS-1:0] result_q;
  reg [4:0] bitsLeft_q;
  reg refEn_q;
  reg evStart_q;
  reg evDone_q;
  reg evRead_q;
  reg pfAssert_q;
  reg supPrev_q;
  reg rstAssert_q;
  reg [31:0] holdCnt_q;
  reg enable_q;
  reg [`ATW_INT_WIDTH-1:0] intStat_q;
  reg [`ATW_INT_WIDTH-1:0] intMask_q;
  reg [`ATW_INT_WIDTH-1:0] intStat_d;
  reg wrPend_q;
  reg [7:0] wrAddr_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  wire sclkFall = sclkPrev_q & ~sclkS;
  wire sclkRise = ~sclkPrev_q & sclkS;
  wire oscTick = (state_q == ST_CONV) && (divCnt_q == DIV_LAST);
  wire [19:0] oscNext = oscCnt_q + 20'h00001;
  // each reduction halves the conversion time
  wire [19:0] convLen = CONV_LEN >> reduce_q;
  wire convEnd = oscTick && (oscNext >= convLen);
  wire winEnd = winOpen_q && oscTick && (oscNext >= WIN_LEN);

  // sclk edges seen one cycle after the second sync stage
  // sync stages reset low, so history starts low: no false fall
  always @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_SLEEP;
      sclkPrev_q <= 1'b0;
      channel_q <= 2'h0;
      reduce_q <= 3'h0;
      winOpen_q <= 1'b0;
      divCnt_q <= 8'h00;
      oscCnt_q <= 20'h00000;
      serial_result_out_q <= 1'b1;
      shift_q <= {RES_BITS{1'b0}};
      result_q <= {RES_BITS{1'b0}};
      bitsLeft_q <= 5'h00;
      refEn_q <= 1'b0;
      evStart_q <= 1'b0;
      evDone_q <= 1'b0;
      evRead_q <= 1'b0;
    end else begin
      sclkPrev_q <= sclkS;
      evStart_q <= 1'b0;
      evDone_q <= 1'b0;
      evRead_q <= 1'b0;
      case (state_q)
        ST_SLEEP: begin
          refEn_q <= 1'b0;
          if (sclkFall && enable_q) begin
            state_q <= ST_CONV;
            channel_q <= {selHighS, selLowS};
            reduce_q <= 3'h0;
            winOpen_q <= 1'b1;
            divCnt_q <= 8'h00;
            oscCnt_q <= 20'h00000;
            serial_result_out_q <= 1'b0;
            refEn_q <= 1'b1;
            evStart_q <= 1'b1;
          end
        end
        ST_CONV: begin
          // oscillator only runs while converting
          if (oscTick) begin
            divCnt_q <= 8'h00;
            oscCnt_q <= oscNext;
          end else begin
            divCnt_q <= divCnt_q + 8'h01;
          end
          if (winEnd) begin
            winOpen_q <= 1'b0;
          end
          if (sclkFall && winOpen_q && !winEnd) begin
            if (reduce_q < REDUCE_MAX) begin
              reduce_q <= reduce_q + 3'h1;
              serial_result_out_q <= 1'b1;
            end
          end else if (sclkRise || winEnd) begin
            serial_result_out_q <= 1'b0;
          end
          if (convEnd) begin
            state_q <= ST_READ;
            winOpen_q <= 1'b0;
            serial_result_out_q <= 1'b1;
            refEn_q <= 1'b0;
            shift_q <= modulatorResult;
            result_q <= modulatorResult;
            bitsLeft_q <= RES_FULL - {2'b00, reduce_q};
            evDone_q <= 1'b1;
          end
        end
        ST_READ: begin
          refEn_q <= 1'b0;
          // sign bit leaves first, then down to bit reduce_q
          if (sclkFall) begin
            serial_result_out_q <= shift_q[RES_BITS-1];
            shift_q <= {shift_q[RES_BITS-2:0], 1'b0};
            bitsLeft_q <= bitsLeft_q - 5'h01;
            if (bitsLeft_q == 5'h01) begin
              state_q <= ST_SLEEP;
              evRead_q <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_SLEEP;
        end
      endcase
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mux
      assign muxInputSel[gi] = (channel_q == gi);
    end
  endgenerate

  // supervisory outputs; reset held after supply recovers
  always @(posedge clk) begin
    if (sys_rst) begin
      pfAssert_q <= 1'b0;
      supPrev_q <= 1'b0;
      rstAssert_q <= 1'b0;
      holdCnt_q <= 32'h0000_0000;
    end else begin
      pfAssert_q <= pfLowS;
      supPrev_q <= supLowS;
      if (supLowS) begin
        rstAssert_q <= 1'b1;
        holdCnt_q <= HOLD_LEN;
      end else if (holdCnt_q != 32'h0000_0000) begin
        holdCnt_q <= holdCnt_q - 32'h0000_0001;
        rstAssert_q <= 1'b1;
      end else begin
        rstAssert_q <= 1'b0;
      end
    end
  end

  // AHB-Lite slave, zero wait states, read data captured at address phase
  wire addrPhase = hsel && hready && htrans[1];
  wire [31:0] wrData = hwdata;
  wire [`ATW_INT_WIDTH-1:0] events = {supLowS & ~supPrev_q,
    pfLowS & ~pfAssert_q, evRead_q, evDone_q, evStart_q};

  always @* begin
    intStat_d = intStat_q;
    if (wrPend_q && wrAddr_q == `ATW_ADDR_INT_STAT) begin
      intStat_d = intStat_q & ~wrData[`ATW_INT_WIDTH-1:0];
    end
    // a new event beats a clear in the same cycle
    intStat_d = intStat_d | events;
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    if (haddr[7:0] == `ATW_ADDR_CTRL) begin
      rdata_d[`ATW_CTRL_ENABLE] = enable_q;
    end else if (haddr[7:0] == `ATW_ADDR_STATUS) begin
      rdata_d[2:0] = state_q;
      rdata_d[5:3] = reduce_q;
      rdata_d[7:6] = channel_q;
      rdata_d[8] = winOpen_q;
      rdata_d[9] = serial_result_out_q;
      rdata_d[10] = pfPinS;
      rdata_d[11] = rstPinS;
      rdata_d[16:12] = bitsLeft_q;
    end else if (haddr[7:0] == `ATW_ADDR_INT_STAT) begin
      rdata_d[`ATW_INT_WIDTH-1:0] = intStat_q;
    end else if (haddr[7:0] == `ATW_ADDR_INT_MASK) begin
      rdata_d[`ATW_INT_WIDTH-1:0] = intMask_q;
    end else if (haddr[7:0] == `ATW_ADDR_RESULT) begin
      rdata_d[RES_BITS-1:0] = result_q;
    end
  end

  always @(posedge clk) begin
    if (sys_rst) begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
      enable_q <= CTRL_RESET[`ATW_CTRL_ENABLE];
      intStat_q <= {`ATW_INT_WIDTH{1'b0}};
      intMask_q <= {`ATW_INT_WIDTH{1'b0}};
    end else begin
      wrPend_q <= addrPhase && hwrite;
      wrAddr_q <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        rdata_q <= rdata_d;
      end
      intStat_q <= intStat_d;
      if (wrPend_q && wrAddr_q == `ATW_ADDR_CTRL) begin
        enable_q <= wrData[`ATW_CTRL_ENABLE];
      end else if (wrPend_q && wrAddr_q == `ATW_ADDR_INT_MASK) begin
        intMask_q <= wrData[`ATW_INT_WIDTH-1:0];
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign irq = |(intStat_q & intMask_q);
  assign serialResultOut = serial_result_out_q;
  assign referenceDriveEn = refEn_q;
  assign powerFailFlagNOut = 1'b0;
  assign powerFailFlagNOeN = ~pfAssert_q;
  assign resetNOut = 1'b0;
  assign resetNOeN = ~rstAssert_q;
endmodule // atw_conv_ctrl

// ---- atw_conv_ctrl_asserts.sv ----
module atw_conv_ctrl_asserts (
  input wire clk,
  input wire sys_rst,
  input wire serialClk,
  input wire serialResultOut,
  input wire [3:0] muxInputSel,
  input wire referenceDriveEn,
  input wire powerFailSenseLow,
  input wire supplyMonitorSenseLow,
  input wire powerFailFlagNOeN,
  input wire resetNOeN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] histQ;
  wire fellRecent = |(histQ[7:1] & ~histQ[6:0]);
  // history spans the synchroniser plus register latency
  always @(posedge clk) histQ <= sys_rst ? 8'hFF : {histQ[6:0], serialClk};
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_start; $rose(referenceDriveEn) |-> fellRecent; endproperty
  a_start: assert property (p_start) else $error("start w/o fall");
  property p_busy; $rose(referenceDriveEn) |-> !serialResultOut; endproperty
  a_busy: assert property (p_busy) else $error("line not busy");
  property p_hold;
    referenceDriveEn && $past(referenceDriveEn) |-> $stable(muxInputSel);
  endproperty
  a_hold: assert property (p_hold) else $error("channel moved");
  property p_mux; $onehot(muxInputSel); endproperty
  a_mux: assert property (p_mux) else $error("mux not onehot");
  property p_ack; referenceDriveEn && serialClk[*6] |-> !serialResultOut;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not lowered");
  property p_done; $fell(referenceDriveEn) |-> ##[0:1] serialResultOut;
  endproperty
  a_done: assert property (p_done) else $error("no done level");
  property p_shift;
    $changed(serialResultOut) && !referenceDriveEn && !$past(referenceDriveEn)
      && !$past(referenceDriveEn, 2) |-> fellRecent;
  endproperty
  a_shift: assert property (p_shift) else $error("bit w/o fall");
  property p_pf; powerFailSenseLow[*5] |-> !powerFailFlagNOeN; endproperty
  a_pf: assert property (p_pf) else $error("flag not low");
  property p_pfOff; !powerFailSenseLow[*5] |-> powerFailFlagNOeN; endproperty
  a_pfOff: assert property (p_pfOff) else $error("flag stuck");
  property p_rst; supplyMonitorSenseLow[*5] |-> !resetNOeN; endproperty
  a_rst: assert property (p_rst) else $error("reset not low");
  property p_rstHold;
    supplyMonitorSenseLow[*5] ##1 !supplyMonitorSenseLow |-> !resetNOeN[*8];
  endproperty
  a_rstHold: assert property (p_rstHold) else $error("early release");
  c_start: cover property ($rose(referenceDriveEn));
  c_done: cover property ($fell(referenceDriveEn));
  c_rst: cover property ($fell(resetNOeN));
endmodule // atw_conv_ctrl_asserts

bind atw_conv_ctrl atw_conv_ctrl_asserts chk_u (.clk(clk), .sys_rst(sys_rst),
  .serialClk(serialClk), .serialResultOut(serialResultOut),
  .muxInputSel(muxInputSel), .referenceDriveEn(referenceDriveEn),
  .powerFailSenseLow(powerFailSenseLow),
  .supplyMonitorSenseLow(supplyMonitorSenseLow),
  .powerFailFlagNOeN(powerFailFlagNOeN), .resetNOeN(resetNOeN));

// ---- atw_host_model.sv ----
module atw_host_model (
  input wire clk,
  input wire serialResultOut,
  output logic serialClk,
  output logic channelSelectLow,
  output logic channelSelectHigh,
  output logic [15:0] word,
  output logic wordValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    serialClk = 1;
    channelSelectLow = 0;
    channelSelectHigh = 0;
    word = 0;
    wordValid = 0;
  end
  // half a link period of 800 ns
  task automatic half(input logic lvl);
    serialClk <= lvl;
    repeat (4) @(posedge clk);
  endtask
  task automatic cycle(input logic [1:0] ch, input int nred, input int nbits);
    int n;
    n = 0;
    {channelSelectHigh, channelSelectLow} <= ch;
    repeat (2) @(posedge clk);
    half(0);
    half(1);
    repeat (nred) begin
      half(0);
      half(1);
    end
    // let the last ack fall before polling for done
    repeat (6) @(posedge clk);
    // no readout asked: a refused start leaves nothing to wait for
    while (nbits != 0 && !serialResultOut && n < 20000) begin
      @(posedge clk);
      n++;
    end
    word = 0;
    repeat (nbits) begin
      half(0);
      half(1);
      word = {word[14:0], serialResultOut};
    end
    wordValid <= (nbits != 0);
    @(posedge clk);
    wordValid <= 0;
  endtask
endmodule // atw_host_model

// ---- testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, hsel = 0, hwrite = 0, pfSense = 0, supSense = 0;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0] htrans = 0;
  logic [15:0] modRes = 0;
  logic rdPend = 0;
  localparam int CONV_T = 4000;
  localparam int DIV_T = 2;
  logic refPrev = 0;
  int convCnt = 0;
  wire hresp;
  wire hready, irq, sdo, sclk, csl, csh, refEn, pfOeN, pfOut, rsOeN, rsOut, wv;
  wire [31:0] hrdata;
  wire [3:0] mux;
  wire [15:0] word;
  wire pfPin = pfOeN ? 1'b1 : pfOut;
  wire rsPin = rsOeN ? 1'b1 : rsOut;
  int failCount = 0, checkCount = 0;
  logic [31:0] rdQ[$];
  logic [15:0] wdQ[$];
  always #50 clk = ~clk;
  atw_conv_ctrl #(.OSC_DIV(DIV_T), .CONV_OSC_CYCLES(CONV_T),
    .WINDOW_OSC_CYCLES(60), .HOLD_CYCLES(10)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .serialClk(sclk),
    .channelSelectLow(csl), .channelSelectHigh(csh),
    .serialResultOut(sdo), .modulatorResult(modRes), .muxInputSel(mux),
    .referenceDriveEn(refEn), .powerFailSenseLow(pfSense),
    .supplyMonitorSenseLow(supSense), .powerFailFlagNIn(pfPin),
    .powerFailFlagNOut(pfOut), .powerFailFlagNOeN(pfOeN),
    .resetNIn(rsPin), .resetNOut(rsOut), .resetNOeN(rsOeN), .irq(irq));
  atw_host_model host_u (.clk(clk), .serialResultOut(sdo), .serialClk(sclk),
    .channelSelectLow(csl), .channelSelectHigh(csh), .word(word),
    .wordValid(wv));
  task automatic cmp(input string what, input logic [31:0] exp, got);
    checkCount++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finalReport;
    $display("checks %0d mismatches %0d", checkCount, failCount);
    if (failCount == 0 && checkCount > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(0, a, 32'h0);
  endtask
  task automatic irqIs(input logic exp);
    repeat (2) @(posedge clk);
    cmp("irq", {31'h0, exp}, {31'h0, irq});
  endtask
  // the monitor pairs each result with the oldest note
  always @(posedge clk) begin
    if (rdPend && hready) cmp("hrdata", rdQ.pop_front(), hrdata);
    if (rdPend && hready) cmp("hresp", 32'h0, {31'h0, hresp});
    if (hready) rdPend <= hsel && htrans[1] && !hwrite;
    if (wv) cmp("word", {16'h0, wdQ.pop_front()}, {16'h0, word});
  end
  // busy length in clk cycles, restarted at each conversion start
  always @(posedge clk) begin
    refPrev <= refEn;
    if (refEn && !refPrev) convCnt <= 1;
    else if (refEn) convCnt <= convCnt + 1;
  end
  initial begin
    #3_000_000;
    failCount++;
    finalReport;
  end
  initial begin
    int red[4] = '{7, 6, 2, 0};
    int r;
    void'($urandom(32'h712F11AB));
    repeat (10) @(posedge clk);
    sys_rst <= 0;
    rd(8'h00, 32'h1);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h04, 32'h0000_0E01);
    bus(1, 8'h0C, 32'h7);
    for (int i = 0; i < 4; i++) begin
      r = red[i] > 6 ? 6 : red[i];
      modRes <= 16'($urandom);
      @(posedge clk);
      wdQ.push_back(modRes >> r);
      host_u.cycle(i[1:0], red[i], 16 - r);
      cmp("convCycles", DIV_T * (CONV_T >> r), convCnt);
      cmp("mux", 32'h1 << i, {28'h0, mux});
      cmp("refEn", 32'h0, {31'h0, refEn});
      rd(8'h10, {16'h0, modRes});
      irqIs(1);
      rd(8'h08, 32'h7);
      bus(1, 8'h08, 32'h7);
      irqIs(0);
    end
    pfSense <= 1;
    repeat (6) @(posedge clk);
    cmp("pfOeN", 32'h0, {31'h0, pfOeN});
    pfSense <= 0;
    supSense <= 1;
    repeat (6) @(posedge clk);
    cmp("pfOeN", 32'h1, {31'h0, pfOeN});
    cmp("rsOeN", 32'h0, {31'h0, rsOeN});
    supSense <= 0;
    repeat (8) @(posedge clk);
    cmp("rsOeN", 32'h0, {31'h0, rsOeN});
    repeat (10) @(posedge clk);
    cmp("rsOeN", 32'h1, {31'h0, rsOeN});
    // masked events must stay off the interrupt line
    rd(8'h08, 32'h18);
    irqIs(0);
    bus(1, 8'h0C, 32'h18);
    irqIs(1);
    bus(1, 8'h08, 32'h18);
    irqIs(0);
    bus(1, 8'h00, 32'h0);
    host_u.cycle(2'b00, 0, 0);
    cmp("refEn", 32'h0, {31'h0, refEn});
    rd(8'h08, 32'h0);
    finalReport;
  end
endmodule // testbench
